// [eeps_pkg.sv]
// Package of constants and carriers for the EEPROM erase/program sequencer
package eeps_pkg;
    // Control register bit positions
    localparam int unsigned CTL_START_BIT = 15; // Start bit
    localparam int unsigned CTL_WEN_BIT = 14; // Write-enable bit
    localparam int unsigned CTL_ERR_BIT = 13; // Write-error flag
    localparam int unsigned CTL_ERASE_BIT = 6; // Erase function
    localparam int unsigned CTL_OP_HI = 6; // Operation field top
    localparam int unsigned CTL_OP_LO = 0; // Operation field bottom
    // Operation codes in the control register
    localparam logic [15:0] CMD_BLOCK_ERASE = 16'h4045; // 16-word erase
    localparam logic [15:0] CMD_WORD_ERASE = 16'h4044; // One-word erase
    localparam logic [15:0] CMD_WORD_PROG = 16'h4004; // One-word program
    localparam logic [6:0] OP_BLOCK_ERASE = 7'h45; // Block erase field
    localparam logic [6:0] OP_WORD_ERASE = 7'h44; // Word erase field
    localparam logic [6:0] OP_WORD_PROG = 7'h04; // Word program field
    // Unlock keys
    localparam logic [7:0] KEY_FIRST = 8'h55; // First key
    localparam logic [7:0] KEY_SECOND = 8'haa; // Second key
    // Reset values
    localparam logic [15:0] CTL_RESET = 16'h0000; // Control reset value
    localparam logic [15:0] ZERO16 = 16'h0000; // Zero word
    localparam logic [6:0] ZERO7 = 7'h00; // Zero upper address
    // Cycle time
    localparam int unsigned CYCLE_TIME_US = 2000; // Erase/program time
    localparam int unsigned CLK_MHZ = 125; // Core clock rate
    localparam int unsigned CYCLE_CLKS = CYCLE_TIME_US * CLK_MHZ;
    // Kind of cycle handed to the array
    typedef enum logic [2:0] {
        EEPS_OP_NONE = 3'b000,
        EEPS_OP_BERASE = 3'b001,
        EEPS_OP_WERASE = 3'b010,
        EEPS_OP_PROG = 3'b100
    } eeps_op_e;
    // Command to the memory array
    typedef struct packed {
        eeps_op_e op; // Operation kind
        logic [22:0] addr; // Word address
        logic [15:0] data; // Latched data
    } eeps_cmd_s;
    // Software write port
    typedef struct packed {
        logic ctl_we; // Control register write
        logic key_we; // Key register write
        logic adl_we; // Low address write
        logic adu_we; // Upper address write
        logic [15:0] wdata; // Write data
    } eeps_swr_s;
endpackage

// [eeps_timer.sv]
// Cycle timer counting the erase/program time
`timescale 1ns/10ps
module eeps_timer
    import eeps_pkg::*;
#(
    parameter int unsigned COUNT = CYCLE_CLKS
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic start,
    output logic done
);
    logic [31:0] cnt; // Cycles left
    logic [31:0] next_cnt;
    logic next_done;
    // Load on start, count down, pulse at the end
    always_comb begin
        next_cnt = cnt;
        next_done = 1'b0;
        if (start) begin
            next_cnt = 32'(COUNT);
        end else if (cnt != 32'h0) begin
            next_cnt = cnt - 32'h1;
            next_done = (cnt == 32'h1);
        end
    end
    // Register the counter
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cnt <= 32'h0;
            done <= 1'b0;
        end else if (clk_en) begin
            cnt <= next_cnt;
            done <= next_done;
        end
    end
endmodule

// [eeps_seq.sv]
// EEPROM erase/program sequencer top
// What this block does
// RL1: Software points address registers at block first
// RL2: Code 4045 selects block erase
// RL3: Code 4044 selects word erase
// RL4: Code 4004 programs latch word
// RL5: Keys 55 then AA precede start
// RL6: Erase takes about 2 ms, no stall
// RL7: Program takes about 2 ms, no stall
// RL8: End clears start, sets done flag
// RL9: Done flag held until software clears
// RL10: Write-enable cleared by hardware only on reset
// RL11: Clearing write-enable leaves cycle running
// RL12: Start needs write-enable from earlier write
// RL13: Table write loads latch, captures address
// RL14: Software erases before programming word
// RL15: Software masks interrupts during unlock
// RL16: Software polls start, flag or timer
// RL17: Software sets start, only hardware clears
// RL18: Reset mid-cycle sets error, keeps address
// RL19: Write-enable clear after power-up
// RL20: Stray write returns unlock tracker idle
`timescale 1ns/10ps
module eeps_seq
    import eeps_pkg::*;
#(
    parameter int unsigned CYCLE_COUNT = CYCLE_CLKS
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic por,
    input wire logic warm_reset,
    input wire eeps_swr_s sw_wr,
    input wire logic tbl_we,
    input wire logic [22:0] tbl_addr,
    input wire logic [15:0] tbl_data,
    input wire logic done_flag_clr,
    input wire logic array_ready,
    output logic [15:0] nv_control_reg,
    output logic [15:0] nv_addr_low_reg,
    output logic [6:0] nv_addr_upper_reg,
    output logic [15:0] write_latch,
    output logic write_done_flag,
    output logic busy,
    output eeps_cmd_s array_cmd,
    output logic array_start
);
    // Unlock tracker states
    typedef enum logic [2:0] {
        UNL_IDLE = 3'b001,
        UNL_KEY1 = 3'b010,
        UNL_KEY2 = 3'b100
    } eeps_unl_e;

    eeps_unl_e unl; // Unlock progress
    eeps_unl_e next_unl;
    logic [15:0] next_ctl;
    logic [15:0] next_adl;
    logic [6:0] next_adu;
    logic [15:0] next_latch;
    logic next_done_flag;
    eeps_cmd_s next_cmd;
    logic next_start;
    logic start_req; // Software asks to set start
    logic start_ok; // Start accepted this cycle
    logic timer_done; // End of cycle pulse
    logic cycle_end; // End of a cycle still running
    logic ctl_start; // Start bit now
    logic op_legal; // Valid operation selected
    eeps_op_e sel_op; // Operation decoded
    logic key_wr; // Any key register write
    logic other_wr; // Address or table write that breaks unlock

    assign ctl_start = nv_control_reg[CTL_START_BIT];
    assign busy = ctl_start;
    // Timer end after an aborted cycle must not raise the flag
    assign cycle_end = timer_done & ctl_start;
    assign key_wr = sw_wr.key_we;
    assign other_wr = sw_wr.adl_we | sw_wr.adu_we | tbl_we;

    // Decode the operation field
    always_comb begin
        sel_op = EEPS_OP_NONE;
        if (nv_control_reg[CTL_OP_HI:CTL_OP_LO] == OP_BLOCK_ERASE) begin
            sel_op = EEPS_OP_BERASE; // see RL2
        end else if (nv_control_reg[CTL_OP_HI:CTL_OP_LO] == OP_WORD_ERASE)
        begin
            sel_op = EEPS_OP_WERASE; // see RL3
        end else if (nv_control_reg[CTL_OP_HI:CTL_OP_LO] == OP_WORD_PROG)
        begin
            sel_op = EEPS_OP_PROG; // see RL4
        end
        op_legal = (sel_op != EEPS_OP_NONE);
    end

    // Start request: control write with start bit, cycle idle
    assign start_req = sw_wr.ctl_we & sw_wr.wdata[CTL_START_BIT] & ~ctl_start;
    // Needs keys done and write-enable held from before
    assign start_ok = start_req & (unl == UNL_KEY2) // see RL5
        & nv_control_reg[CTL_WEN_BIT] & op_legal; // see RL12

    // Unlock tracker next state
    always_comb begin
        next_unl = unl;
        case (unl)
            UNL_IDLE: begin
                if (key_wr && sw_wr.wdata[7:0] == KEY_FIRST) begin
                    next_unl = UNL_KEY1; // see RL5
                end
            end
            UNL_KEY1: begin
                if (key_wr && sw_wr.wdata[7:0] == KEY_SECOND) begin
                    next_unl = UNL_KEY2;
                end else if (key_wr || sw_wr.ctl_we || other_wr) begin
                    next_unl = UNL_IDLE; // see RL20
                end
            end
            UNL_KEY2: begin
                if (key_wr || sw_wr.ctl_we || other_wr) begin
                    next_unl = UNL_IDLE; // see RL20
                end
            end
            default: begin
                next_unl = UNL_IDLE;
            end
        endcase
    end

    // Control, address, latch and flag next values
    always_comb begin
        next_ctl = nv_control_reg;
        next_adl = nv_addr_low_reg;
        next_adu = nv_addr_upper_reg;
        next_latch = write_latch;
        next_done_flag = write_done_flag;
        next_cmd = array_cmd;
        next_start = 1'b0;
        // Software control write: start bit only set via start_ok
        if (sw_wr.ctl_we && !ctl_start) begin
            next_ctl[CTL_WEN_BIT] = sw_wr.wdata[CTL_WEN_BIT];
            next_ctl[CTL_ERR_BIT] = sw_wr.wdata[CTL_ERR_BIT];
            next_ctl[CTL_OP_HI:CTL_OP_LO] = sw_wr.wdata[CTL_OP_HI:CTL_OP_LO];
        end else if (sw_wr.ctl_we) begin
            // Running cycle keeps its operation; enable may change
            next_ctl[CTL_WEN_BIT] = sw_wr.wdata[CTL_WEN_BIT]; // see RL11
            next_ctl[CTL_ERR_BIT] = sw_wr.wdata[CTL_ERR_BIT];
        end
        if (start_ok) begin
            next_ctl[CTL_START_BIT] = 1'b1; // see RL17
            next_start = 1'b1;
            next_cmd.op = sel_op;
            next_cmd.addr = {nv_addr_upper_reg, nv_addr_low_reg};
            next_cmd.data = write_latch;
        end
        // Completion clears start; enable untouched
        if (cycle_end) begin
            next_ctl[CTL_START_BIT] = 1'b0; // see RL8
            next_done_flag = 1'b1; // see RL8
        end else if (done_flag_clr) begin
            next_done_flag = 1'b0; // see RL9
        end
        // Address registers, frozen while running
        if (!ctl_start && !start_ok) begin
            if (tbl_we) begin
                next_adl = tbl_addr[15:0]; // see RL13
                next_adu = tbl_addr[22:16];
                next_latch = tbl_data; // see RL13
            end else begin
                if (sw_wr.adl_we) begin
                    next_adl = sw_wr.wdata;
                end
                if (sw_wr.adu_we) begin
                    next_adu = sw_wr.wdata[6:0];
                end
            end
        end
        // Interrupted cycle: flag error, clear start
        if (warm_reset) begin
            next_ctl[CTL_ERR_BIT] = ctl_start | nv_control_reg[CTL_ERR_BIT];
            next_ctl[CTL_START_BIT] = 1'b0; // see RL18
            next_ctl[CTL_WEN_BIT] = 1'b0;
            next_start = 1'b0;
            next_adl = nv_addr_low_reg; // see RL18
            next_adu = nv_addr_upper_reg;
        end
        // Power-up clears write-enable and the rest of the control register
        if (por) begin
            next_ctl = CTL_RESET; // see RL19
        end
    end

    // Register unlock tracker
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            unl <= UNL_IDLE;
        end else if (clk_en) begin
            unl <= (por | warm_reset) ? UNL_IDLE : next_unl;
        end
    end

    // Register control and data state
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            nv_control_reg <= CTL_RESET; // see RL19
            nv_addr_low_reg <= ZERO16;
            nv_addr_upper_reg <= ZERO7;
            write_latch <= ZERO16;
            write_done_flag <= 1'b0;
            array_cmd <= '0;
            array_start <= 1'b0;
        end else if (clk_en) begin
            nv_control_reg <= next_ctl;
            nv_addr_low_reg <= next_adl;
            nv_addr_upper_reg <= next_adu;
            write_latch <= next_latch;
            write_done_flag <= next_done_flag;
            array_cmd <= next_cmd;
            array_start <= next_start;
        end
    end

    // Background cycle timer, processor never stalled
    eeps_timer #(
        .COUNT(CYCLE_COUNT)
    ) u_timer (
        .core_clk(core_clk),
        .reset(reset),
        .clk_en(clk_en & ~warm_reset & ~por & array_ready), // see RL6
        .start(start_ok), // see RL7
        .done(timer_done)
    );

    // Start accepted only after both keys
    property p_start_needs_keys;
        @(posedge core_clk) disable iff (reset)
        $rose(ctl_start) |-> $past(unl == UNL_KEY2 && sw_wr.ctl_we
            && sw_wr.wdata[CTL_START_BIT]); // see RL5
    endproperty
    a_start_needs_keys: assert property (p_start_needs_keys) // see RL5
        else $error("start without unlock keys");

    // Start bit rises only with enable set before
    property p_wen_before;
        @(posedge core_clk) disable iff (reset)
        $rose(ctl_start) |-> $past(nv_control_reg[CTL_WEN_BIT]);
    endproperty
    a_wen_before: assert property (p_wen_before) // see RL12
        else $error("start set without prior enable");

    // Done flag never falls without a clear
    property p_flag_sticky;
        @(posedge core_clk) disable iff (reset)
        $fell(write_done_flag) |-> $past(done_flag_clr);
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) // see RL9
        else $error("done flag cleared by itself");

    // End of cycle clears start and sets flag
    property p_end;
        @(posedge core_clk) disable iff (reset)
        (clk_en && cycle_end && !warm_reset && !por)
            |=> (!ctl_start && write_done_flag);
    endproperty
    a_end: assert property (p_end) // see RL8
        else $error("cycle end not reported");

    // Enable never falls except by software write or reset
    property p_wen_kept;
        @(posedge core_clk) disable iff (reset)
        $fell(nv_control_reg[CTL_WEN_BIT])
            |-> $past(sw_wr.ctl_we || warm_reset || por);
    endproperty
    a_wen_kept: assert property (p_wen_kept) // see RL10
        else $error("enable cleared by hardware");

    // Start bit falls only at cycle end or reset
    property p_start_fall;
        @(posedge core_clk) disable iff (reset)
        $fell(ctl_start) |-> $past(cycle_end || warm_reset || por);
    endproperty
    a_start_fall: assert property (p_start_fall) // see RL17
        else $error("start cleared early");

    // Table write captures address when idle
    sequence s_tbl_idle;
        clk_en && tbl_we && !ctl_start && !start_ok && !warm_reset;
    endsequence
    property p_tbl_capture;
        @(posedge core_clk) disable iff (reset)
        s_tbl_idle |=> (nv_addr_low_reg == $past(tbl_addr[15:0])
            && write_latch == $past(tbl_data));
    endproperty
    a_tbl_capture: assert property (p_tbl_capture) // see RL13
        else $error("table write not captured");

    // Interrupted cycle flags error
    property p_err;
        @(posedge core_clk) disable iff (reset)
        (clk_en && warm_reset && ctl_start && !por)
            |=> nv_control_reg[CTL_ERR_BIT];
    endproperty
    a_err: assert property (p_err) // see RL18
        else $error("interrupted cycle not flagged");
endmodule

// [eeps_sw_model.sv]
// Software model making register and table writes to the sequencer
`timescale 1ns/10ps
module eeps_sw_model
    import eeps_pkg::*;
(
    input wire logic core_clk,
    output eeps_swr_s sw_wr,
    output logic tbl_we,
    output logic [22:0] tbl_addr,
    output logic [15:0] tbl_data,
    output logic done_flag_clr
);
    // Idle values at time zero
    initial begin
        sw_wr = '0;
        tbl_we = 1'b0;
        tbl_addr = '0;
        tbl_data = '0;
        done_flag_clr = 1'b0;
    end
    // Register write: 0 control, 1 key, 2 low address, 3 upper address
    task automatic wr(input int k, input logic [15:0] d);
        @(posedge core_clk);
        sw_wr <= '{k == 0, k == 1, k == 2, k == 3, d};
        @(posedge core_clk);
        // Released data shows the inverse, never a stale value
        sw_wr <= '{1'b0, 1'b0, 1'b0, 1'b0, ~d};
    endtask
    // Table write into the data space
    task automatic tbl(input logic [22:0] a, input logic [15:0] d);
        @(posedge core_clk);
        tbl_we <= 1'b1;
        tbl_addr <= a;
        tbl_data <= d;
        @(posedge core_clk);
        tbl_we <= 1'b0;
        tbl_addr <= ~a;
        tbl_data <= ~d;
    endtask
    // Both keys, then the start bit, with nothing in between
    task automatic unlock_start(input logic [15:0] c);
        wr(1, {8'h00, KEY_FIRST});
        wr(1, {8'h00, KEY_SECOND});
        wr(0, c | 16'h8000);
    endtask
    // Software clear of the completion flag
    task automatic clr_flag();
        @(posedge core_clk);
        done_flag_clr <= 1'b1;
        @(posedge core_clk);
        done_flag_clr <= 1'b0;
    endtask
endmodule

// [testbench.sv]
// Self-checking testbench for the erase/program sequencer
`timescale 1ns/10ps
module testbench
    import eeps_pkg::*;
;
    localparam int CC = 20; // Shortened cycle time
    logic core_clk, reset, clk_en, por, warm_reset, array_ready;
    eeps_swr_s sw_wr;
    logic tbl_we, done_flag_clr, write_done_flag, busy, array_start;
    logic [22:0] tbl_addr;
    logic [15:0] tbl_data, nv_control_reg, nv_addr_low_reg, write_latch;
    logic [6:0] nv_addr_upper_reg;
    eeps_cmd_s array_cmd;
    int n_errors = 0;
    int cmp_count = 0;
    int n;
    // Rows: command, operation, address, data (program row last)
    logic [15:0] r_cmd [3] = '{CMD_BLOCK_ERASE, CMD_WORD_ERASE, CMD_WORD_PROG};
    eeps_op_e r_op [3] = '{EEPS_OP_BERASE, EEPS_OP_WERASE, EEPS_OP_PROG};
    logic [22:0] r_adr [3] = '{23'h7ffc00, 23'h7ffc22, 23'h7ffd3e};
    logic [15:0] r_dat [3] = '{16'h0000, 16'h0000, 16'ha5c3};

    eeps_seq #(.CYCLE_COUNT(CC)) uut (.core_clk(core_clk), .reset(reset),
        .clk_en(clk_en), .por(por), .warm_reset(warm_reset), .sw_wr(sw_wr),
        .tbl_we(tbl_we), .tbl_addr(tbl_addr), .tbl_data(tbl_data),
        .done_flag_clr(done_flag_clr), .array_ready(array_ready),
        .nv_control_reg(nv_control_reg), .nv_addr_low_reg(nv_addr_low_reg),
        .nv_addr_upper_reg(nv_addr_upper_reg), .write_latch(write_latch),
        .write_done_flag(write_done_flag), .busy(busy),
        .array_cmd(array_cmd), .array_start(array_start));
    eeps_sw_model sw (.core_clk(core_clk), .sw_wr(sw_wr), .tbl_we(tbl_we),
        .tbl_addr(tbl_addr), .tbl_data(tbl_data),
        .done_flag_clr(done_flag_clr));

    // Clock generator
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // Word comparison
    task automatic chk_w(input logic [15:0] g, input logic [15:0] e,
                         input string m);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h want %h", $time, m, g, e);
        end
    endtask
    // Bit comparison
    task automatic chk_b(input logic g, input logic e, input string m);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: %s got %b", $time, m, g);
        end
    endtask
    // Clock edges, then let updates settle
    task automatic step(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    // Select the command, unlock and start, expect acceptance
    task automatic start_ok(input logic [15:0] c);
        sw.wr(0, c);
        sw.unlock_start(c);
        #1;
        chk_b(busy, 1'b1, "start accepted");
        chk_b(array_start, 1'b1, "array start pulse");
    endtask
    // Poll the flag, bounded, and check the cycle length
    task automatic finish(input int lo);
        n = 0;
        while (write_done_flag !== 1'b1 && n < 1000) begin
            step(1);
            n++;
        end
        chk_b(n >= lo && n <= lo + 2, 1'b1, "cycle length");
        chk_b(busy, 1'b0, "start cleared at end");
    endtask
    // One line as each test ends
    task automatic end_test(input string s);
        $display("test %s done at %0t", s, $time);
    endtask
    // Counts, verdict and end of run
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Watchdog against a hang
    initial begin
        repeat (4000) @(posedge core_clk);
        n_errors++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        reset = 1'b1;
        clk_en = 1'b1;
        por = 1'b0;
        warm_reset = 1'b0;
        array_ready = 1'b1;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        step(1);
        chk_w(nv_control_reg, CTL_RESET, "control at reset");
        chk_b(write_done_flag, 1'b0, "flag at reset");
        end_test("reset");
        // Erase rows come before the program row
        for (int i = 0; i < 3; i++) begin
            if (i == 2) begin
                sw.tbl(r_adr[i], r_dat[i]);
            end else begin
                sw.wr(3, {9'h000, r_adr[i][22:16]});
                sw.wr(2, r_adr[i][15:0]);
            end
            step(1);
            chk_w(nv_addr_low_reg, r_adr[i][15:0], "low address");
            chk_w({9'h000, nv_addr_upper_reg}, {9'h000, r_adr[i][22:16]},
                  "upper address");
            chk_w(write_latch, r_dat[i], "latch");
            start_ok(r_cmd[i]);
            chk_w({13'h0000, array_cmd.op}, {13'h0000, r_op[i]},
                  "operation");
            chk_w(array_cmd.addr[15:0], r_adr[i][15:0],
                  "array address");
            chk_w({9'h000, array_cmd.addr[22:16]}, {9'h000, r_adr[i][22:16]},
                  "array upper");
            chk_w(array_cmd.data, r_dat[i], "array data");
            finish(CC);
            chk_w(nv_control_reg, r_cmd[i], "control after");
            step(5);
            chk_b(write_done_flag, 1'b1, "flag held");
            sw.clr_flag();
            step(1);
            chk_b(write_done_flag, 1'b0, "flag cleared");
            end_test("row");
        end
        // Power-up clear, then enable and start in one write
        @(posedge core_clk);
        por <= 1'b1;
        @(posedge core_clk);
        por <= 1'b0;
        step(1);
        chk_w(nv_control_reg, CTL_RESET, "after power-up");
        sw.unlock_start(CMD_BLOCK_ERASE);
        step(2);
        chk_b(busy, 1'b0, "same-write start");
        end_test("same write");
        // Stray write between the keys
        sw.wr(0, CMD_BLOCK_ERASE);
        sw.wr(1, {8'h00, KEY_FIRST});
        sw.wr(2, 16'h0c1e);
        sw.wr(1, {8'h00, KEY_SECOND});
        sw.wr(0, 16'hc045);
        step(2);
        chk_b(busy, 1'b0, "stray write start");
        // Keys in the wrong order
        sw.wr(1, {8'h00, KEY_SECOND});
        sw.wr(1, {8'h00, KEY_FIRST});
        sw.wr(0, 16'hc045);
        step(2);
        chk_b(busy, 1'b0, "wrong key order");
        end_test("bad keys");
        // Enable cleared by software mid-cycle; start written 0 but kept
        start_ok(CMD_WORD_ERASE);
        sw.wr(0, 16'h0044);
        #1;
        chk_b(busy, 1'b1, "start kept");
        // Freeze three edges; the cycle must stretch by as many
        @(posedge core_clk);
        clk_en <= 1'b0;
        repeat (3) @(posedge core_clk);
        clk_en <= 1'b1;
        #1;
        chk_w(nv_control_reg, 16'h8044, "frozen control");
        finish(CC - 2);
        chk_w(nv_control_reg, 16'h0044, "enable cleared");
        sw.clr_flag();
        end_test("mid clear");
        // Warm reset mid-cycle
        start_ok(CMD_WORD_ERASE);
        @(posedge core_clk);
        warm_reset <= 1'b1;
        @(posedge core_clk);
        warm_reset <= 1'b0;
        step(1);
        chk_b(nv_control_reg[CTL_ERR_BIT], 1'b1, "error flag");
        chk_b(busy, 1'b0, "start after warm reset");
        chk_w(nv_addr_low_reg, 16'h0c1e, "address kept");
        step(CC + 2);
        chk_b(write_done_flag, 1'b0, "no done after abort");
        end_test("warm reset");
        report_and_stop();
    end
endmodule
